//--- rtl/sysctl_pkg.sv
// Constants and carrier types for the system-control register bank
`default_nettype none
package sysctl_pkg;
  // Coprocessor operand encodings
  localparam logic [3:0] CRN_SYS      = 4'hF;
  localparam logic [2:0] OP1_PWR      = 3'h0;
  localparam logic [2:0] OP1_BASE     = 3'h4;
  localparam logic [2:0] OP1_LOCK     = 3'h5;
  localparam logic [3:0] CRM_PWR      = 4'h0;
  localparam logic [3:0] CRM_BUSY     = 4'h1;
  localparam logic [3:0] CRM_BASE     = 4'h0;
  localparam logic [3:0] CRM_SEL      = 4'h4;
  localparam logic [3:0] CRM_VA       = 4'h5;
  localparam logic [3:0] CRM_PA       = 4'h6;
  localparam logic [3:0] CRM_ATTR     = 4'h7;
  localparam logic [2:0] OP2_PWR      = 3'h0;
  localparam logic [2:0] OP2_BUSY     = 3'h0;
  localparam logic [2:0] OP2_BASE     = 3'h0;
  localparam logic [2:0] OP2_LOCK     = 3'h2;
  localparam logic [2:0] OP2_SEL_RD   = 3'h2;
  localparam logic [2:0] OP2_SEL_WR   = 3'h4;
  // Field positions
  localparam int         PWR_LAT_LO   = 8;
  localparam int         PWR_LAT_W    = 3;
  localparam int         PWR_GATE_BIT = 0;
  localparam int         BUSY_BIT     = 0;
  localparam int         BASE_LO      = 13;
  localparam int         BASE_W       = 19;
  localparam int         VA_VPN_LO    = 12;
  localparam int         VA_NS_BIT    = 10;
  localparam int         VA_MSI_W     = 10;
  // Read masks for reserved bits
  localparam logic [31:0] VA_MASK     = 32'hFFFFF7FF;
  // Reset values
  localparam logic              GATE_RST = 1'b0;
  localparam logic [2:0]        LAT_RST  = 3'h0;
  localparam logic [BASE_W-1:0] BASE_RST = 19'h00000;
  localparam logic [31:0]       WORD_RST = 32'h00000000;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        secure;
    logic        privileged;
    logic [2:0]  op1;
    logic [3:0]  crn;
    logic [3:0]  crm;
    logic [2:0]  op2;
    logic [31:0] wdata;
  } cp_req_t;

  typedef struct packed {
    logic        done;
    logic        undef;
    logic [31:0] rdata;
  } cp_rsp_t;

  typedef struct packed {
    logic [31:0] va;
    logic [31:0] pa;
    logic [31:0] attr;
  } tlb_entry_t;

  typedef enum logic {
    ST_CAPTURE = 1'b0,
    ST_RUN     = 1'b1
  } boot_state_t;
endpackage
`default_nettype wire

//--- rtl/pin_sync.sv
// Two-flop synchroniser for static input pins
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // Data path only, no reset, so the pins are settled by release
  always_ff @(posedge mclk) begin
    if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

//--- rtl/core_sysctl_c15_regs.sv
// System-control register bank: power, vector busy, base, TLB lockdown
// Operation
// R1: Power control writable only when Secure; Non-secure writes ignored.
// R2: On reset exit, latency pins are captured into power control bits 10:8.
// R3: Software should leave the captured latency field unchanged.
// R4: Power control bit 0 enables dynamic clock gating, reset to zero.
// R5: Power control is opcode1 0, CRn 15, CRm 0, opcode2 0.
// R6: Vector busy register is read-only, at opcode1 0, CRm 1, opcode2 0.
// R7: Vector busy bit 0 reads 1 while a vector instruction is in flight.
// R8: Base register resets to zero single-core, to base pins multi-core.
// R9: Base register writable only Secure privileged; otherwise read-only.
// R10: Base register is opcode1 4, CRn 15, CRm 0, opcode2 0.
// R11: Lockdown ops at opcode1 5; CRm 4 selects, CRm 5-7 VA, PA, attributes.
// R12: Select-for-read latches index; VA/PA/attribute reads return that entry.
// R13: Select-for-write latches an index; VA/PA/attribute writes go there.
// R14: Software accesses the PA register last in a lockdown sequence.
// R15: VA holds page number 31:12, non-secure tag 10, space id 9:0.
// R16: Untranslated page number bits read unpredictable; software writes zero.
// R17: All lockdown operations are refused from the Non-secure state.
// R18: A PA write commits staged VA, attributes and PA into the entry.
// R19: Reserved bits of power and busy registers read zero, ignore writes.
`default_nettype none
module core_sysctl_c15_regs #(
  parameter bit MULTI_CORE  = 1'b1,
  parameter int TLB_ENTRIES = 4,
  parameter int IDX_W       = 2
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire sysctl_pkg::cp_req_t         req,
  input  wire logic                        vector_pipe_busy,
  input  wire logic                        core_pipe_vector,
  input  wire logic [2:0]                  max_clock_latency_pins,
  input  wire logic [31:0]                 private_region_base_input,
  output sysctl_pkg::cp_rsp_t              rsp,
  output logic                             dyn_clock_gating_en,
  output logic [2:0]                       max_clock_latency,
  output logic [sysctl_pkg::BASE_W-1:0]    config_base
);
  logic [2:0]                    lat_sync;
  logic [31:0]                   base_sync;
  sysctl_pkg::boot_state_t       state;
  sysctl_pkg::boot_state_t       next_state;
  logic                          next_gate;
  logic [2:0]                    next_lat;
  logic [sysctl_pkg::BASE_W-1:0] next_base;
  sysctl_pkg::cp_rsp_t           next_rsp;
  logic [IDX_W-1:0]              rd_index;
  logic [IDX_W-1:0]              wr_index;
  logic [IDX_W-1:0]              next_rd_index;
  logic [IDX_W-1:0]              next_wr_index;
  logic [31:0]                   stage_va;
  logic [31:0]                   stage_attr;
  logic [31:0]                   next_stage_va;
  logic [31:0]                   next_stage_attr;
  logic                          commit;
  sysctl_pkg::tlb_entry_t        commit_entry;
  sysctl_pkg::tlb_entry_t        entries [TLB_ENTRIES];
  logic                          is_pwr;
  logic                          is_busy;
  logic                          is_base;
  logic                          is_lock;
  logic                          is_selr;
  logic                          is_selw;
  logic                          is_va;
  logic                          is_pa;
  logic                          is_attr;
  logic                          legal;
  logic                          take;
  logic                          busy_now;

  // Configuration pins arrive from outside the core clock domain
  pin_sync #(.W(3)) u_lat_sync (
    .mclk (mclk),
    .ce   (ce),
    .d    (max_clock_latency_pins),
    .q    (lat_sync)
  );

  pin_sync #(.W(32)) u_base_sync (
    .mclk (mclk),
    .ce   (ce),
    .d    (private_region_base_input),
    .q    (base_sync)
  );

  // Operand decode
  always_comb begin
    is_pwr  = req.op1 == sysctl_pkg::OP1_PWR && req.crn == sysctl_pkg::CRN_SYS
              && req.crm == sysctl_pkg::CRM_PWR
              && req.op2 == sysctl_pkg::OP2_PWR; // R5
    is_busy = req.op1 == sysctl_pkg::OP1_PWR && req.crn == sysctl_pkg::CRN_SYS
              && req.crm == sysctl_pkg::CRM_BUSY
              && req.op2 == sysctl_pkg::OP2_BUSY; // R6
    is_base = req.op1 == sysctl_pkg::OP1_BASE
              && req.crn == sysctl_pkg::CRN_SYS
              && req.crm == sysctl_pkg::CRM_BASE
              && req.op2 == sysctl_pkg::OP2_BASE; // R10
    is_lock = req.op1 == sysctl_pkg::OP1_LOCK
              && req.crn == sysctl_pkg::CRN_SYS; // R11
    is_selr = is_lock && req.crm == sysctl_pkg::CRM_SEL
              && req.op2 == sysctl_pkg::OP2_SEL_RD; // R11
    is_selw = is_lock && req.crm == sysctl_pkg::CRM_SEL
              && req.op2 == sysctl_pkg::OP2_SEL_WR; // R11
    is_va   = is_lock && req.crm == sysctl_pkg::CRM_VA
              && req.op2 == sysctl_pkg::OP2_LOCK;
    is_pa   = is_lock && req.crm == sysctl_pkg::CRM_PA
              && req.op2 == sysctl_pkg::OP2_LOCK;
    is_attr = is_lock && req.crm == sysctl_pkg::CRM_ATTR
              && req.op2 == sysctl_pkg::OP2_LOCK;
    // Lockdown space is invisible to Non-secure software
    legal   = is_pwr || (is_busy && !req.write) || is_base
              || (req.secure && (is_va || is_pa || is_attr))
              || (req.secure && req.write && (is_selr || is_selw)); // R17
    busy_now = vector_pipe_busy || core_pipe_vector; // R7
  end

  // Next-value logic for the whole bank
  always_comb begin
    next_state      = state;
    next_gate       = dyn_clock_gating_en;
    next_lat        = max_clock_latency;
    next_base       = config_base;
    next_rd_index   = rd_index;
    next_wr_index   = wr_index;
    next_stage_va   = stage_va;
    next_stage_attr = stage_attr;
    commit          = 1'b0;
    commit_entry    = '{va: stage_va, pa: req.wdata, attr: stage_attr};
    next_rsp        = '{done: 1'b0, undef: 1'b0,
                        rdata: sysctl_pkg::WORD_RST};
    take            = 1'b0;
    unique case (state)
      sysctl_pkg::ST_CAPTURE: begin
        // First cycle after release: pins have had two edges to settle
        next_lat = lat_sync; // R2
        next_base = MULTI_CORE ?
          base_sync[sysctl_pkg::BASE_LO +: sysctl_pkg::BASE_W] :
          sysctl_pkg::BASE_RST; // R8
        next_state = sysctl_pkg::ST_RUN;
      end
      sysctl_pkg::ST_RUN: begin
        take = req.valid;
      end
    endcase
    if (take) begin
      next_rsp.done  = 1'b1;
      next_rsp.undef = !legal;
      if (legal && req.write) begin
        if (is_pwr && req.secure) begin // R1
          next_gate = req.wdata[sysctl_pkg::PWR_GATE_BIT]; // R4
          next_lat  = req.wdata[sysctl_pkg::PWR_LAT_LO +:
                                sysctl_pkg::PWR_LAT_W];
        end
        if (is_base && req.secure && req.privileged) begin // R9
          next_base = req.wdata[sysctl_pkg::BASE_LO +: sysctl_pkg::BASE_W];
        end
        if (is_selr) begin
          next_rd_index = req.wdata[IDX_W-1:0]; // R12
        end
        if (is_selw) begin
          next_wr_index = req.wdata[IDX_W-1:0]; // R13
        end
        if (is_va) begin
          next_stage_va = req.wdata & sysctl_pkg::VA_MASK; // R15
        end
        if (is_attr) begin
          next_stage_attr = req.wdata;
        end
        // PA goes last, so it is the one that lands the whole entry
        commit = is_pa; // R18 R14
      end
      if (legal && !req.write) begin
        if (is_pwr) begin
          next_rsp.rdata[sysctl_pkg::PWR_GATE_BIT] = dyn_clock_gating_en;
          next_rsp.rdata[sysctl_pkg::PWR_LAT_LO +: sysctl_pkg::PWR_LAT_W] =
            max_clock_latency; // R19
        end
        if (is_busy) begin
          next_rsp.rdata[sysctl_pkg::BUSY_BIT] = busy_now; // R7 R19
        end
        if (is_base) begin
          next_rsp.rdata[sysctl_pkg::BASE_LO +: sysctl_pkg::BASE_W] =
            config_base;
        end
        // Stored page bits are returned as is for untranslated positions
        if (is_va) begin
          next_rsp.rdata = entries[rd_index].va
                           & sysctl_pkg::VA_MASK; // R12 R16
        end
        if (is_pa) begin
          next_rsp.rdata = entries[rd_index].pa; // R12
        end
        if (is_attr) begin
          next_rsp.rdata = entries[rd_index].attr; // R12
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state               <= sysctl_pkg::ST_CAPTURE;
      dyn_clock_gating_en <= sysctl_pkg::GATE_RST; // R4
      max_clock_latency   <= sysctl_pkg::LAT_RST;
      config_base         <= sysctl_pkg::BASE_RST;
      rd_index            <= '0;
      wr_index            <= '0;
      stage_va            <= sysctl_pkg::WORD_RST;
      stage_attr          <= sysctl_pkg::WORD_RST;
      rsp                 <= '0;
      for (int i = 0; i < TLB_ENTRIES; i++) begin
        entries[i] <= '0;
      end
    end else if (ce) begin
      state               <= next_state;
      dyn_clock_gating_en <= next_gate;
      max_clock_latency   <= next_lat;
      config_base         <= next_base;
      rd_index            <= next_rd_index;
      wr_index            <= next_wr_index;
      stage_va            <= next_stage_va;
      stage_attr          <= next_stage_attr;
      rsp                 <= next_rsp;
      if (commit) begin
        entries[wr_index] <= commit_entry; // R13 R18
      end
    end
  end

  // Helpers for the checks below
  logic        h_take_pwr_wr;
  logic        h_take_base_wr;
  logic [31:0] h_wdata;
  logic [31:0] h_rd_va;
  logic        h_busy;
  logic [sysctl_pkg::BASE_W-1:0] h_base_pins;
  always_comb begin
    h_take_pwr_wr  = ce && take && req.write && is_pwr;
    h_take_base_wr = ce && take && req.write && is_base;
    h_wdata        = req.wdata;
    h_rd_va        = entries[rd_index].va & sysctl_pkg::VA_MASK;
    h_busy         = busy_now;
    h_base_pins    = base_sync[sysctl_pkg::BASE_LO +: sysctl_pkg::BASE_W];
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_pwr_ns_hold: assert property ( // R1
    h_take_pwr_wr && !req.secure |=>
      $stable(dyn_clock_gating_en) && $stable(max_clock_latency))
    else $error("Non-secure write changed power control");

  a_pwr_gate_write: assert property ( // R4
    h_take_pwr_wr && req.secure |=>
      dyn_clock_gating_en == $past(h_wdata[0]))
    else $error("Secure power write did not set gating bit");

  a_latency_capture: assert property ( // R2
    ce && !rst && state == sysctl_pkg::ST_CAPTURE |=>
      max_clock_latency == $past(lat_sync) && state == sysctl_pkg::ST_RUN)
    else $error("Latency pins not captured on reset exit");

  a_gate_reset_off: assert property ( // R4
    $fell(rst) |-> !dyn_clock_gating_en)
    else $error("Clock gating enabled out of reset");

  a_busy_read_bit: assert property ( // R7
    ce && take && !req.write && is_busy |=>
      rsp.done && !rsp.undef && rsp.rdata == {31'h0, $past(h_busy)})
    else $error("Busy register read wrong");

  a_pwr_reserved_zero: assert property ( // R19
    ce && take && !req.write && is_pwr |=>
      rsp.rdata[31:11] == 21'h0 && rsp.rdata[7:1] == 7'h0)
    else $error("Power reserved bits not zero");

  a_base_guard_hold: assert property ( // R9
    h_take_base_wr && !(req.secure && req.privileged) |=>
      $stable(config_base))
    else $error("Base changed by unprivileged or Non-secure write");

  // Sampled reset in the antecedent keeps the release edge itself out
  a_base_reset_load: assert property ( // R8
    ce && !rst && state == sysctl_pkg::ST_CAPTURE |=>
      config_base == (MULTI_CORE ? $past(h_base_pins) : sysctl_pkg::BASE_RST))
    else $error("Base not loaded correctly on reset exit");

  a_lock_ns_refuse: assert property ( // R17
    ce && take && is_lock && !req.secure |=> rsp.done && rsp.undef)
    else $error("Non-secure lockdown access not refused");

  a_va_read_entry: assert property ( // R12 R15
    ce && take && !req.write && is_va && req.secure |=>
      rsp.rdata == $past(h_rd_va) && rsp.rdata[11] == 1'b0)
    else $error("Lockdown VA read mismatch");

  a_pa_commit: assert property ( // R18
    ce && take && req.write && is_pa && req.secure |=>
      entries[$past(wr_index)].pa == $past(h_wdata)
      && entries[$past(wr_index)].va == $past(stage_va))
    else $error("PA write did not commit entry");
endmodule
`default_nettype wire

//--- verification/core_sysctl_c15_regs_tb_top.sv
// Self-checking bench for the system-control register bank
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module core_sysctl_c15_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                              mclk;
  logic                              rst;
  logic                              ce;
  sysctl_pkg::cp_req_t               req;
  logic                              vector_pipe_busy;
  logic                              core_pipe_vector;
  logic [2:0]                        max_clock_latency_pins;
  logic [31:0]                       private_region_base_input;
  sysctl_pkg::cp_rsp_t               rsp;
  sysctl_pkg::cp_rsp_t               r;
  logic                              dyn_clock_gating_en;
  logic [2:0]                        max_clock_latency;
  logic [sysctl_pkg::BASE_W-1:0]     config_base;
  int                                error_cnt;
  int                                checked;
  logic [31:0]                       va [4];
  logic [31:0]                       pa [4];
  logic [31:0]                       at [4];

  core_sysctl_c15_regs #(
    .MULTI_CORE (1'b1),
    .TLB_ENTRIES(4),
    .IDX_W      (2)
  ) dut (
    .mclk                     (mclk),
    .rst                      (rst),
    .ce                       (ce),
    .req                      (req),
    .vector_pipe_busy         (vector_pipe_busy),
    .core_pipe_vector         (core_pipe_vector),
    .max_clock_latency_pins   (max_clock_latency_pins),
    .private_region_base_input(private_region_base_input),
    .rsp                      (rsp),
    .dyn_clock_gating_en      (dyn_clock_gating_en),
    .max_clock_latency        (max_clock_latency),
    .config_base              (config_base)
  );

  initial begin
    mclk = 1'b0;
  end

  always #50 mclk = ~mclk;

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One access: request stands for one edge, answer sampled 1 ns after that same edge
  task automatic acc(input logic w, input logic s, input logic p,
                     input logic [2:0] o1, input logic [3:0] cm,
                     input logic [2:0] o2, input logic [31:0] wd);
    @(posedge mclk);
    req <= sysctl_pkg::cp_req_t'{valid: 1'b1, write: w, secure: s,
      privileged: p, op1: o1, crn: sysctl_pkg::CRN_SYS, crm: cm, op2: o2,
      wdata: wd};
    @(posedge mclk);
    req <= '0;
    #1 r = rsp;
    `CHK(r.done, 1'b1)
  endtask

  task automatic rd(input logic s, input logic [2:0] o1,
                    input logic [3:0] cm, input logic [2:0] o2);
    acc(1'b0, s, 1'b1, o1, cm, o2, 32'h00000000);
  endtask

  task automatic lk(input logic w, input logic [3:0] cm,
                    input logic [2:0] o2, input logic [31:0] wd);
    acc(w, 1'b1, 1'b1, sysctl_pkg::OP1_LOCK, cm, o2, wd);
  endtask

  initial begin
    repeat (3000) @(posedge mclk);
    error_cnt++;
    end_of_test();
  end

  initial begin
    error_cnt = 0;
    checked = 0;
    rst = 1'b1;
    ce = 1'b1;
    req = '0;
    vector_pipe_busy = 1'b0;
    core_pipe_vector = 1'b0;
    max_clock_latency_pins = 3'h5;
    private_region_base_input = 32'hABCDE000;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    `CHK(max_clock_latency, 3'h5)
    `CHK(dyn_clock_gating_en, 1'b0)
    `CHK(config_base, 19'h55E6F)
    rd(1'b1, 3'h0, sysctl_pkg::CRM_PWR, 3'h0);
    `CHK(r.rdata, 32'h00000500)
    // Non-secure write must leave the register as it was
    acc(1'b1, 1'b0, 1'b1, 3'h0, sysctl_pkg::CRM_PWR, 3'h0, 32'hFFFFFFFF);
    `CHK(r.undef, 1'b0)
    rd(1'b0, 3'h0, sysctl_pkg::CRM_PWR, 3'h0);
    `CHK(r.rdata, 32'h00000500)
    // Software writes the captured latency back unchanged
    acc(1'b1, 1'b1, 1'b1, 3'h0, sysctl_pkg::CRM_PWR, 3'h0, 32'hFFFFF5FF);
    #1;
    `CHK(dyn_clock_gating_en, 1'b1)
    `CHK(max_clock_latency, 3'h5)
    rd(1'b1, 3'h0, sysctl_pkg::CRM_PWR, 3'h0);
    `CHK(r.rdata, 32'h00000501)
    // Busy bit from either pipe
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      vector_pipe_busy <= k[0];
      core_pipe_vector <= k[1];
      rd(1'b0, 3'h0, sysctl_pkg::CRM_BUSY, 3'h0);
      `CHK(r.rdata, {31'h0, k[0] | k[1]})
    end
    acc(1'b1, 1'b1, 1'b1, 3'h0, sysctl_pkg::CRM_BUSY, 3'h0, 32'h1);
    `CHK(r.undef, 1'b1)
    // Base register: only Secure privileged writes land
    acc(1'b1, 1'b0, 1'b1, 3'h4, sysctl_pkg::CRM_BASE, 3'h0,
        32'h12346000);
    acc(1'b1, 1'b1, 1'b0, 3'h4, sysctl_pkg::CRM_BASE, 3'h0,
        32'h12346000);
    rd(1'b0, 3'h4, sysctl_pkg::CRM_BASE, 3'h0);
    `CHK(r.rdata, 32'hABCDE000)
    acc(1'b1, 1'b1, 1'b1, 3'h4, sysctl_pkg::CRM_BASE, 3'h0,
        32'h12346000);
    #1;
    `CHK(config_base, 19'h091A3)
    rd(1'b1, 3'h4, sysctl_pkg::CRM_BASE, 3'h0);
    `CHK(r.rdata, 32'h12346000)
    // Fill every lockdown entry, PA written last
    for (int i = 0; i < 4; i++) begin
      va[i] = 32'hA0000C00 | 32'(i);
      at[i] = 32'h00000F00 + 32'(i);
      pa[i] = 32'h50000001 + 32'(i << 12);
      lk(1'b1, sysctl_pkg::CRM_SEL, sysctl_pkg::OP2_SEL_WR, 32'(i));
      lk(1'b1, sysctl_pkg::CRM_VA, 3'h2, va[i]);
      lk(1'b1, sysctl_pkg::CRM_ATTR, 3'h2, at[i]);
      lk(1'b1, sysctl_pkg::CRM_PA, 3'h2, pa[i]);
    end
    // Staged VA without a PA write must not reach the entry
    lk(1'b1, sysctl_pkg::CRM_SEL, sysctl_pkg::OP2_SEL_WR, 32'h0);
    lk(1'b1, sysctl_pkg::CRM_VA, 3'h2, 32'h12345000);
    for (int i = 3; i >= 0; i--) begin
      lk(1'b1, sysctl_pkg::CRM_SEL, sysctl_pkg::OP2_SEL_RD, 32'(i));
      lk(1'b0, sysctl_pkg::CRM_VA, 3'h2, 32'h0);
      `CHK(r.rdata, va[i] & 32'hFFFFF7FF)
      lk(1'b0, sysctl_pkg::CRM_ATTR, 3'h2, 32'h0);
      `CHK(r.rdata, at[i])
      lk(1'b0, sysctl_pkg::CRM_PA, 3'h2, 32'h0);
      `CHK(r.rdata, pa[i])
    end
    lk(1'b0, sysctl_pkg::CRM_SEL, sysctl_pkg::OP2_SEL_RD, 32'h0);
    `CHK(r.undef, 1'b1)
    acc(1'b1, 1'b0, 1'b1, 3'h5, sysctl_pkg::CRM_SEL, 3'h2, 32'h1);
    `CHK(r.undef, 1'b1)
    rd(1'b0, 3'h5, sysctl_pkg::CRM_VA, 3'h2);
    `CHK(r.undef, 1'b1)
    `CHK(r.undef, r.done)
    rd(1'b1, 3'h1, sysctl_pkg::CRM_PWR, 3'h0);
    `CHK(r.undef, 1'b1)
    end_of_test();
  end
endmodule
`default_nettype wire
